// ==== hdl/scs_regs.vh ====
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// Command selector codes carried with each written word
`define SCS_SEL_STEP0 3'h0
`define SCS_SEL_STEP1 3'h1
`define SCS_SEL_STEP2 3'h2
`define SCS_SEL_STEP3 3'h3
`define SCS_SEL_SIGNED 3'h4
`define SCS_SEL_STAMP 3'h5

// Step command word fields
`define SCS_STEP_CNT_MSB 12
`define SCS_STEP_DIR_BIT 13
`define SCS_STEP_CUR_LSB 14

// Motor current codes
`define SCS_CUR_OFF 2'h0
`define SCS_CUR_HOLD 2'h1
`define SCS_CUR_NOM 2'h2
`define SCS_CUR_MAX 2'h3

// Configuration bit positions
`define SCS_CFG1_WORDS_LSB 3
`define SCS_CFG_LAYOUT_BIT 0
`define SCS_LIFE_CHECK_BIT 6
`define SCS_ACK_BIT 5

// Transfer value count codes
`define SCS_WORDS_ONE 2'h0
`define SCS_WORDS_TWO 2'h1
`define SCS_WORDS_FOUR 2'h2

// Error word bit positions
`define SCS_ERR_STALL 0
`define SCS_ERR_HEAT 1
`define SCS_ERR_WIND 2
`define SCS_ERR_SURGE 3
`define SCS_ERR_HEALTH 4

// Limits and timing
`define SCS_TEMP_LIMIT_C 8'h55
`define SCS_SURGE_FACTOR 2
`define SCS_CLK_PERIOD_NS 40
`define SCS_CYCLE_TIME_NS 1000000
`define SCS_CYCLE_CLKS (`SCS_CYCLE_TIME_NS / `SCS_CLK_PERIOD_NS)
`define SCS_RESET_ALIVE 8'h00
`define SCS_MICRO_PER_STEP 256

`endif

// ==== hdl/scs_stepper_cyclic.v ====
// Overview of operation
// R01: Bits 0-12 steps, bit 13 direction
// R02: Bits 14-15 choose motor current level
// R03: Word count per cycle from config bits 3-4
// R04: Setting 00: word 0 for whole cycle
// R05: 01 halves words 0-1; 10 quarters 0-3
// R06: Signed value gives 1/256 step distance; code gives one step pulse per unit, unscaled
// R07: Sign of value selects direction
// R08: Life-sign bit 6 checks fresh time stamp
// R09: Alive counter adds one every cycle
// R10: Alive counter wraps 127 to -128
// R11: Config bit 0 picks status byte layout
// R12: Life-sign model forces digital input layout
// R13: Status bit 0 supply fault, bit 1 reserved
// R14: Digital layout: bits 2-5 inputs 1-4
// R15: Counter layout: bit 2 toggles per homing
// R16: Bit 3 homing done; bits 4-5 inputs 3-4
// R17: Error bits 0-3 latched until acknowledged
// R18: Acknowledge by writing 1 to bit 5
// R19: Overheat from stage or module above 85C
// R20: Winding fault when current cannot flow
// R21: Surge when current reaches twice configured
// R22: Bit 4 drive health with life-sign only
// R23: Health needs all drive conditions true
// R24: Zero step count gives no pulses
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.vh"

module scs_fifo #(
   parameter WIDTH = 19,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rstn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] fill_r;
   wire push;
   wire pop;

   assign in_ready = (fill_r != DEPTH[AW:0]);
   assign out_valid = (fill_r != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         fill_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            fill_r <= fill_r + 1'b1;
         end else if (pop && !push) begin
            fill_r <= fill_r - 1'b1;
         end
      end
   end
endmodule

module scs_stepper_cyclic #(
   parameter CYCLE_CLKS = `SCS_CYCLE_CLKS,
   parameter CNT_W = 16,
   parameter FIFO_DEPTH = 4
) (
   input wire clk,
   input wire rstn,
   input wire cycle_start,
   input wire cmd_valid,
   output wire cmd_ready,
   input wire [2:0] cmd_sel,
   input wire [15:0] cmd_data,
   input wire signed_mode,
   input wire [7:0] module_cfg,
   input wire [7:0] module_cfg1,
   input wire [7:0] life_sign_cfg,
   input wire life_sign_model,
   input wire ack_valid,
   input wire [7:0] ack_data,
   input wire supply_fault_flag,
   input wire [3:0] digital_in,
   input wire homing_done_pulse,
   input wire homing_active,
   input wire stall_event,
   input wire stage_overheat,
   input wire [7:0] module_temp_c,
   input wire winding_open,
   input wire [7:0] meas_current,
   input wire [7:0] cfg_current,
   input wire ground_check_ok,
   input wire motor_id_done,
   input wire motor_energized,
   input wire settle_done,
   output reg step_pulse,
   output reg step_dir,
   output reg [1:0] current_sel,
   output reg setpoint_valid,
   output reg [7:0] cycle_alive_counter,
   output reg [7:0] input_homing_status,
   output reg [15:0] drive_error_word
);
   localparam [CNT_W-1:0] CYC = CYCLE_CLKS[CNT_W-1:0];

   wire fifo_valid;
   wire fifo_ready;
   wire [18:0] fifo_data;
   wire [2:0] f_sel;
   wire [15:0] f_word;

   reg [15:0] pend_r [0:3];
   reg [15:0] act_r [0:3];
   reg [15:0] pend_signed_r;
   reg [15:0] act_signed_r;
   reg [15:0] pend_stamp_r;
   reg [15:0] last_stamp_r;
   reg stamp_new_r;
   reg act_signed_mode_r;
   reg [1:0] words_r;
   reg [1:0] slot_r;
   reg [CNT_W-1:0] slot_cnt_r;
   reg [CNT_W:0] acc_r;
   reg homing_tgl_r;
   reg [3:0] err_r;
   reg [CNT_W:0] acc_nxt;
   reg [15:0] cur_word;
   reg [CNT_W-1:0] slot_len;
   reg [15:0] steps;
   reg [1:0] last_slot;
   integer i;

   // Slot length in clocks for the selected split
   function [CNT_W-1:0] slot_clks;
      input [1:0] words;
      begin
         case (words)
            `SCS_WORDS_TWO: slot_clks = CYC >> 1;
            `SCS_WORDS_FOUR: slot_clks = CYC >> 2;
            default: slot_clks = CYC;
         endcase
      end
   endfunction

   // Magnitude of a signed 16-bit value
   function [15:0] mag16;
      input [15:0] v;
      begin
         mag16 = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   // Words are buffered so a burst from the bus is not lost
   scs_fifo #(
      .WIDTH(19),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data({cmd_sel, cmd_data}),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // Draining stalls at cycle start so pending copy and write never collide
   assign fifo_ready = !cycle_start;
   assign f_sel = fifo_data[18:16];
   assign f_word = fifo_data[15:0];

   always @* begin
      last_slot = 2'h0;
      case (words_r)
         `SCS_WORDS_TWO: last_slot = 2'h1; // see R05
         `SCS_WORDS_FOUR: last_slot = 2'h3; // see R05
         default: last_slot = 2'h0; // see R04
      endcase
      slot_len = slot_clks(words_r);
      cur_word = act_r[slot_r];
      if (act_signed_mode_r) begin
         steps = mag16(act_signed_r); // see R06
      end else begin
         steps = {3'h0, cur_word[`SCS_STEP_CNT_MSB:0]}; // see R01
      end
      acc_nxt = acc_r + {{(CNT_W+1-16){1'b0}}, steps};
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 4; i = i + 1) begin
            pend_r[i] <= 16'h0000;
            act_r[i] <= 16'h0000;
         end
         pend_signed_r <= 16'h0000;
         act_signed_r <= 16'h0000;
         pend_stamp_r <= 16'h0000;
         last_stamp_r <= 16'h0000;
         stamp_new_r <= 1'b0;
         act_signed_mode_r <= 1'b0;
         words_r <= `SCS_WORDS_ONE;
         slot_r <= 2'h0;
         slot_cnt_r <= {CNT_W{1'b0}};
         acc_r <= {(CNT_W+1){1'b0}};
         step_pulse <= 1'b0;
         step_dir <= 1'b0;
         current_sel <= `SCS_CUR_OFF;
         setpoint_valid <= 1'b0;
         cycle_alive_counter <= `SCS_RESET_ALIVE;
      end else begin
         if (fifo_valid && fifo_ready) begin
            case (f_sel)
               `SCS_SEL_STEP0: pend_r[0] <= f_word;
               `SCS_SEL_STEP1: pend_r[1] <= f_word;
               `SCS_SEL_STEP2: pend_r[2] <= f_word;
               `SCS_SEL_STEP3: pend_r[3] <= f_word;
               `SCS_SEL_SIGNED: pend_signed_r <= f_word;
               `SCS_SEL_STAMP: begin
                  pend_stamp_r <= f_word;
                  stamp_new_r <= 1'b1;
               end
               default: begin
               end
            endcase
         end
         step_pulse <= 1'b0;
         if (cycle_start) begin
            for (i = 0; i < 4; i = i + 1) begin
               act_r[i] <= pend_r[i];
            end
            act_signed_r <= pend_signed_r;
            act_signed_mode_r <= signed_mode;
            words_r <= module_cfg1[`SCS_CFG1_WORDS_LSB+1:`SCS_CFG1_WORDS_LSB]; // see R03
            slot_r <= 2'h0;
            slot_cnt_r <= {CNT_W{1'b0}};
            acc_r <= {1'b0,
                      slot_clks(module_cfg1[`SCS_CFG1_WORDS_LSB+1:`SCS_CFG1_WORDS_LSB]) - 1'b1};
            cycle_alive_counter <= cycle_alive_counter + 8'h01; // see R09, R10
            if (life_sign_cfg[`SCS_LIFE_CHECK_BIT]) begin
               setpoint_valid <= stamp_new_r && (pend_stamp_r != last_stamp_r); // see R08
            end else begin
               setpoint_valid <= 1'b1;
            end
            last_stamp_r <= pend_stamp_r;
            stamp_new_r <= 1'b0;
         end else begin
            // Spread the slot's steps evenly over its clocks
            // Each slot starts one short of a step, so a slot cut by a clock keeps its count
            if (steps != 16'h0000 && acc_nxt >= {1'b0, slot_len}) begin
               step_pulse <= 1'b1; // see R01, R06
            end
            if (slot_cnt_r == slot_len - 1'b1) begin
               slot_cnt_r <= {CNT_W{1'b0}};
               acc_r <= {1'b0, slot_len - 1'b1};
               if (slot_r != last_slot) begin
                  slot_r <= slot_r + 2'h1; // see R05
               end
            end else begin
               slot_cnt_r <= slot_cnt_r + 1'b1;
               // At most one pulse per clock; faster demands are clipped
               if (steps == 16'h0000 || acc_nxt < {1'b0, slot_len}) begin
                  acc_r <= acc_nxt; // see R24
               end else if (acc_nxt - {1'b0, slot_len} >= {1'b0, slot_len}) begin
                  acc_r <= {1'b0, slot_len - 1'b1};
               end else begin
                  acc_r <= acc_nxt - {1'b0, slot_len};
               end
            end
            if (act_signed_mode_r) begin
               step_dir <= act_signed_r[15]; // see R07
            end else begin
               step_dir <= cur_word[`SCS_STEP_DIR_BIT]; // see R01
            end
            current_sel <= cur_word[`SCS_STEP_CUR_LSB+1:`SCS_STEP_CUR_LSB]; // see R02, R24
         end
      end
   end

   wire layout_counter;
   wire heat_now;
   wire surge_now;
   wire ack_now;
   wire health;
   wire [8:0] surge_limit;
   wire [31:0] surge_prod;

   assign layout_counter = module_cfg[`SCS_CFG_LAYOUT_BIT] && !life_sign_model; // see R11, R12
   assign heat_now = stage_overheat || (module_temp_c > `SCS_TEMP_LIMIT_C); // see R19
   assign surge_prod = cfg_current * `SCS_SURGE_FACTOR;
   assign surge_limit = surge_prod[8:0];
   assign surge_now = ({1'b0, meas_current} >= surge_limit) && (cfg_current != 8'h00); // see R21
   // Writing 0 to the acknowledge bit leaves the latches alone
   assign ack_now = ack_valid && ack_data[`SCS_ACK_BIT]; // see R18
   assign health = (current_sel != `SCS_CUR_OFF) && ground_check_ok && motor_id_done &&
                   motor_energized && settle_done && !supply_fault_flag &&
                   !err_r[`SCS_ERR_HEAT] && setpoint_valid && (err_r == 4'h0); // see R22, R23

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         homing_tgl_r <= 1'b0;
         err_r <= 4'h0;
         input_homing_status <= 8'h00;
         drive_error_word <= 16'h0000;
      end else begin
         if (homing_done_pulse) begin
            homing_tgl_r <= ~homing_tgl_r; // see R15
         end
         // A new event in the acknowledge cycle stays latched
         err_r[`SCS_ERR_STALL] <= stall_event || (err_r[`SCS_ERR_STALL] && !ack_now); // see R17
         err_r[`SCS_ERR_HEAT] <= heat_now || (err_r[`SCS_ERR_HEAT] && !ack_now); // see R17
         err_r[`SCS_ERR_WIND] <= winding_open || (err_r[`SCS_ERR_WIND] && !ack_now); // see R20
         err_r[`SCS_ERR_SURGE] <= surge_now || (err_r[`SCS_ERR_SURGE] && !ack_now); // see R17
         if (layout_counter) begin
            input_homing_status <= {2'b00, digital_in[3], digital_in[2], !homing_active,
                                    homing_tgl_r, 1'b0, supply_fault_flag}; // see R13, R16
         end else begin
            input_homing_status <= {2'b00, digital_in, 1'b0, supply_fault_flag}; // see R14
         end
         drive_error_word <= {11'h000, life_sign_model && health, err_r}; // see R22
      end
   end
endmodule

`default_nettype wire

// ==== dv/scs_stepper_cyclic_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module scs_stepper_cyclic_assertions (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cycle_start,
   input wire logic ack_valid,
   input wire logic [7:0] ack_data,
   input wire logic supply_fault_flag,
   input wire logic [3:0] digital_in,
   input wire logic [7:0] module_cfg,
   input wire logic life_sign_model,
   input wire logic homing_active,
   input wire logic [7:0] meas_current,
   input wire logic [7:0] cfg_current,
   input wire logic stall_event,
   input wire logic stage_overheat,
   input wire logic winding_open,
   input wire logic [7:0] module_temp_c,
   input wire logic ground_check_ok,
   input wire logic motor_id_done,
   input wire logic motor_energized,
   input wire logic settle_done,
   input wire logic [7:0] cycle_alive_counter,
   input wire logic [7:0] input_homing_status,
   input wire logic [15:0] drive_error_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_alive_inc;
      cycle_start |=> cycle_alive_counter == $past(cycle_alive_counter) + 8'h01;
   endproperty
   a_alive_inc: assert property (p_alive_inc) else $error("alive count step");
   property p_alive_hold;
      !cycle_start |=> $stable(cycle_alive_counter);
   endproperty
   a_alive_hold: assert property (p_alive_hold) else $error("alive count moved");
   property p_supply;
      $past(rstn) |-> input_homing_status[0] == $past(supply_fault_flag);
   endproperty
   a_supply: assert property (p_supply) else $error("supply bit");
   property p_digital;
      $past(rstn) && $past(life_sign_model || !module_cfg[0])
         |-> input_homing_status[5:2] == $past(digital_in);
   endproperty
   a_digital: assert property (p_digital) else $error("digital layout");
   property p_counter;
      $past(rstn) && $past(!life_sign_model && module_cfg[0])
         |-> input_homing_status[5:3] == {$past(digital_in[3:2]), !$past(homing_active)};
   endproperty
   a_counter: assert property (p_counter) else $error("counter layout");
   property p_err_hold;
      !(ack_valid && ack_data[5]) |-> ##2 (drive_error_word[3:0] & $past(drive_error_word[3:0]))
         == $past(drive_error_word[3:0]);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error bit lost");
   property p_err_clear;
      ack_valid && ack_data[5] && !stall_event && !stage_overheat && !winding_open
         && module_temp_c <= 8'h55
         && !(cfg_current != 8'h00 && {1'b0, meas_current} >= {cfg_current, 1'b0})
         |-> ##2 drive_error_word[3:0] == 4'h0;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("ack failed");
   property p_surge;
      cfg_current != 8'h00 && {1'b0, meas_current} >= {cfg_current, 1'b0}
         |-> ##2 drive_error_word[3];
   endproperty
   a_surge: assert property (p_surge) else $error("surge not set");
   property p_health_off;
      !life_sign_model |=> !drive_error_word[4];
   endproperty
   a_health_off: assert property (p_health_off) else $error("health shown");
   property p_health_need;
      drive_error_word[4] |-> $past(ground_check_ok && motor_id_done && motor_energized
         && settle_done && !supply_fault_flag);
   endproperty
   a_health_need: assert property (p_health_need) else $error("health too early");
endmodule
`default_nettype wire

// ==== dv/scs_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module scs_ctrl_model #(
   parameter int PERIOD = 64
) (
   input wire logic clk,
   input wire logic run,
   output var logic cycle_start,
   output var logic ack_valid,
   output var logic [7:0] ack_data
);
   int cnt = 0;
   initial begin
      cycle_start = 1'b0;
      ack_valid = 1'b0;
      ack_data = 8'h00;
   end
   // Fixed-rate boundary, like a fieldbus master
   always @(negedge clk) begin
      cnt <= (run && cnt < PERIOD - 1) ? cnt + 1 : 0;
      cycle_start <= run && cnt == PERIOD - 1;
   end
   // Released byte is inverted so stale data never looks valid
   task automatic ack(input logic [7:0] b);
      @(negedge clk);
      ack_data = b;
      ack_valid = 1'b1;
      @(negedge clk);
      ack_valid = 1'b0;
      ack_data = ~b;
   endtask
endmodule
`default_nettype wire

// ==== dv/scs_stepper_cyclic_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module scs_stepper_cyclic_tb_top;
   localparam int CYC = 64;
   logic clk = 1'b0, rstn = 1'b0, run = 1'b0, cycle_start, ack_valid, tgl;
   logic cmd_valid = 1'b0, signed_mode = 1'b0, life_sign_model = 1'b0, supply_fault_flag = 1'b0;
   logic homing_done_pulse = 1'b0, homing_active = 1'b0, stall_event = 1'b0, stage_overheat = 1'b0;
   logic winding_open = 1'b0, ground_check_ok = 1'b1, motor_id_done = 1'b1, motor_energized = 1'b1;
   logic settle_done = 1'b1, cmd_ready, step_pulse, step_dir, setpoint_valid;
   logic [2:0] cmd_sel = 3'h0;
   logic [15:0] cmd_data = 16'h0000, drive_error_word;
   logic [7:0] module_cfg = 8'h00, module_cfg1 = 8'h00, life_sign_cfg = 8'h00, ack_data;
   logic [7:0] module_temp_c = 8'h19, meas_current = 8'h00, cfg_current = 8'h0A;
   logic [7:0] cycle_alive_counter, input_homing_status;
   logic [3:0] digital_in = 4'h0;
   logic [1:0] current_sel;
   int err_count = 0, samples_checked = 0, ncyc = 0;
   int cnt [4];
   int ex [4] = '{5, 3, 0, 2};
   always #20 clk = ~clk;
   always @(posedge clk) if (cycle_start === 1'b1) ncyc <= ncyc + 1;
   scs_ctrl_model #(.PERIOD(CYC)) i_ctl (.clk, .run, .cycle_start, .ack_valid, .ack_data);
   scs_stepper_cyclic #(.CYCLE_CLKS(CYC)) i_dut (.clk, .rstn, .cycle_start, .cmd_valid,
      .cmd_ready, .cmd_sel, .cmd_data, .signed_mode, .module_cfg, .module_cfg1, .life_sign_cfg,
      .life_sign_model, .ack_valid, .ack_data, .supply_fault_flag, .digital_in, .homing_done_pulse,
      .homing_active, .stall_event, .stage_overheat, .module_temp_c, .winding_open, .meas_current,
      .cfg_current, .ground_check_ok, .motor_id_done, .motor_energized, .settle_done, .step_pulse,
      .step_dir, .current_sel, .setpoint_valid, .cycle_alive_counter, .input_homing_status,
      .drive_error_word);
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      logic ok;
      cmd_sel = s;
      cmd_data = d;
      cmd_valid = 1'b1;
      do begin
         ok = cmd_ready;
         @(negedge clk);
      end while (ok !== 1'b1);
   endtask
   task automatic idle;
      cmd_valid = 1'b0;
      cmd_data = ~cmd_data;
   endtask
   task automatic sync;
      @(posedge clk iff cycle_start === 1'b1);
      @(negedge clk);
   endtask
   task automatic meas(input int n, input logic d, input logic [1:0] c);
      int got;
      cnt = '{0, 0, 0, 0};
      for (int k = 0; k < CYC; k++) begin
         @(negedge clk);
         cnt[k / 16] += step_pulse;
         if (k == 4) `CHK({step_dir, current_sel}, {d, c})
      end
      for (int s = 0; s < n; s++) begin
         got = 0;
         for (int q = 0; q < 4; q++) if (q * n / 4 == s) got += cnt[q];
         `CHK(got, ex[s])
      end
   endtask
   task automatic cause(input int i, input logic v);
      case (i)
         0: stall_event = v;
         1: stage_overheat = v;
         2: winding_open = v;
         3: meas_current = v ? 8'h14 : 8'h13;
         default: module_temp_c = v ? 8'h56 : 8'h55;
      endcase
   endtask
   task automatic end_of_test;
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      `CHK(cycle_alive_counter, 8'h00)
      run = 1'b1;
      for (int r = 0; r < 4; r++) begin
         sync;
         module_cfg1 = {3'h0, r[1:0], 3'h0};
         wr(3'h0, {r[1:0], 1'b1, 13'h0005});
         wr(3'h1, 16'h0003);
         wr(3'h2, 16'h0000);
         wr(3'h3, 16'h0002);
         idle;
         sync;
         meas(r == 1 ? 2 : r == 2 ? 4 : 1, 1'b1, r[1:0]);
      end
      signed_mode = 1'b1;
      module_cfg1 = 8'h00;
      for (int i = 0; i < 2; i++) begin
         sync;
         wr(3'h4, i ? 16'hFFEC : 16'h0028);
         idle;
         sync;
         ex[0] = i ? 20 : 40;
         meas(1, i[0], 2'h3);
      end
      signed_mode = 1'b0;
      life_sign_cfg = 8'h40;
      sync;
      wr(3'h5, 16'h1234);
      idle;
      sync;
      `CHK(setpoint_valid, 1'b1)
      sync;
      `CHK(setpoint_valid, 1'b0)
      life_sign_cfg = 8'h00;
      sync;
      `CHK(setpoint_valid, 1'b1)
      life_sign_model = 1'b1;
      repeat (3) @(negedge clk);
      `CHK(drive_error_word[4], 1'b1)
      ground_check_ok = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(drive_error_word[4], 1'b0)
      ground_check_ok = 1'b1;
      supply_fault_flag = 1'b1;
      digital_in = 4'hA;
      module_cfg = 8'h01;
      repeat (2) @(negedge clk);
      `CHK({input_homing_status[5:2], input_homing_status[0]}, 5'h15)
      life_sign_model = 1'b0;
      supply_fault_flag = 1'b0;
      homing_active = 1'b1;
      @(negedge clk);
      tgl = input_homing_status[2];
      homing_done_pulse = 1'b1;
      @(negedge clk);
      homing_done_pulse = 1'b0;
      homing_active = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(input_homing_status[3:2], {1'b1, ~tgl})
      life_sign_model = 1'b1;
      for (int i = 0; i < 5; i++) begin
         cause(i, 1'b1);
         @(negedge clk);
         cause(i, 1'b0);
         repeat (2) @(negedge clk);
         `CHK(drive_error_word[4:0], 5'h01 << (i == 4 ? 1 : i))
         i_ctl.ack(8'hDF);
         `CHK(drive_error_word[3:0], 4'h1 << (i == 4 ? 1 : i))
         i_ctl.ack(8'h20);
         @(negedge clk);
         `CHK(drive_error_word[3:0], 4'h0)
      end
      for (int v = 127; v < 129; v++) begin
         wait (ncyc == v);
         @(negedge clk);
         `CHK(cycle_alive_counter, v[7:0])
      end
      end_of_test;
   end
   initial begin
      #(40 * 20000);
      err_count++;
      end_of_test;
   end
endmodule
bind scs_stepper_cyclic scs_stepper_cyclic_assertions i_chk (.clk, .rstn, .cycle_start,
   .ack_valid, .ack_data, .supply_fault_flag, .digital_in, .module_cfg, .life_sign_model,
   .homing_active, .meas_current, .cfg_current, .stall_event, .stage_overheat, .winding_open,
   .module_temp_c, .ground_check_ok, .motor_id_done,
   .motor_energized, .settle_done, .cycle_alive_counter, .input_homing_status, .drive_error_word);
`default_nettype wire
